// >>> pkg/split_host_bus_pkg.sv
/*
 * constants used by the host end and the bench of the split host bus port; the device end uses none.
 * assumes a single 100 MHz clock on each end.
 */
`default_nettype none
package split_host_bus_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    // sync stages for asynchronous strobes
    localparam int SYNC_STAGES = 2;
    // internal memory access latency in cycles
    localparam int MEM_LATENCY = 2;
    // host-side strobe width and timeout, in cycles
    localparam int HOST_STROBE_CYC = 4;
    localparam int HOST_TIMEOUT_CYC = 64;
    localparam logic [3:0] HOST_STROBE_CNT = 4'(HOST_STROBE_CYC);
    localparam logic [6:0] HOST_TIMEOUT_CNT = 7'(HOST_TIMEOUT_CYC);
    localparam logic [1:0] MEM_LAT_CNT = 2'(MEM_LATENCY);
endpackage
`default_nettype wire

// >>> pkg/split_host_bus_if.sv
/*
 * pin-level carrier between the host end and the device end.
 * resolves the data bus itself; the host end qualifies the acknowledge line with its enable.
 */
`timescale 1ns/1ps
`default_nettype none
interface split_host_bus_if;
    logic [10:0] addr;
    logic [7:0]  data_from_host;
    logic        data_from_host_oe;
    logic [7:0]  data_from_dev;
    logic        data_from_dev_oe;
    logic        access_enable_n;
    logic        lower_data_strobe;
    logic        read_strobe_n;
    logic        store_strobe_n;
    logic        direction_select;
    logic        transfer_ready;
    logic        transfer_ready_oe;
    logic        transfer_acknowledge_n;
    logic        transfer_acknowledge_oe;
    logic        service_request_out;
    logic        request_polarity_pin;
    logic        strobe_style_select;
    logic        multiplexed_bus_select;
    // resolved data seen by both parties
    logic [7:0]  data_bus;
    assign data_bus = data_from_dev_oe ? data_from_dev :
                      (data_from_host_oe ? data_from_host : 8'hFF);

    modport device (
        input  addr, data_bus, access_enable_n, lower_data_strobe, read_strobe_n,
               store_strobe_n, direction_select, request_polarity_pin,
               strobe_style_select, multiplexed_bus_select,
        output data_from_dev, data_from_dev_oe, transfer_ready, transfer_ready_oe,
               transfer_acknowledge_n, transfer_acknowledge_oe, service_request_out
    );
    modport host (
        input  data_bus, transfer_ready, transfer_ready_oe, transfer_acknowledge_n,
               transfer_acknowledge_oe, service_request_out, strobe_style_select,
        output addr, data_from_host, data_from_host_oe, access_enable_n,
               lower_data_strobe, read_strobe_n, store_strobe_n, direction_select
    );
endinterface
`default_nettype wire

// >>> logic/split_host_bus_dev.sv
/*
 * device end of the split host bus port: syncs host strobes, issues one
 * internal read or write per host cycle, answers with ready or acknowledge.
 * assumes the internal memory answers reads after a fixed latency.
 */
// What this block does
// RULE1: non-multiplexed bus; style pin picks strobe set
// RULE2: 11-bit word address, bit 10 highest
// RULE3: 8-bit data, driven only on reads
// RULE4: no transfer unless access enable is low
// RULE5: ready style: read strobe low reads
// RULE6: ready style: store strobe low writes
// RULE7: acknowledge style: direction high reads, low writes
// RULE8: internal select is enable OR lower strobe; the code ORs them only in acknowledge style, ready style uses enable alone
// RULE9: unused lower strobe is tied to ground
// RULE10: ready high when transfer can complete
// RULE11: ready low forces host wait states
// RULE12: read acknowledge only with valid data
// RULE13: write acknowledge confirms data taken
// RULE14: acknowledge line released when idle
// RULE15: polarity high: request drives high
// RULE16: polarity low: request drives low
// RULE17: polarity pin strapped to host's need
// RULE18: strobes synchronised, one access per cycle
`timescale 1ns/1ps
`default_nettype none
module split_host_bus_dev (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // host pins
    split_host_bus_if.device bus,
    // internal memory side
    output logic             mem_rd,
    output logic             mem_wr,
    output logic [10:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        mem_rvalid,
    input  wire logic        irq_pending
);
    typedef enum logic [2:0] {IDLE, RD_WAIT, ANSWER, RELEASE} state_e;

    state_e     state_q;
    logic [1:0] sel_sync_q;
    logic [1:0] rd_sync_q;
    logic [1:0] wr_sync_q;
    logic       is_read_q;
    logic [7:0] rdata_q;
    logic       sel_n;
    logic       rd_req;
    logic       wr_req;
    logic       ack_style;
    logic       stale_q;
    logic       answer_live;

    // read strobe decode, shared by the synchroniser and the data drive
    function automatic logic pin_read(input logic ack, input logic dir, input logic rd_n);
        return ack ? dir : !rd_n;
    endfunction

    // write strobe decode for either style
    function automatic logic pin_write(input logic ack, input logic dir, input logic wr_n);
        return ack ? !dir : !wr_n;
    endfunction

    // acknowledge style only when the multiplexed bus is off
    assign ack_style = !bus.multiplexed_bus_select && bus.strobe_style_select; // [RULE1]

    // internal select: enable alone or ORed with lower strobe
    assign sel_n = ack_style ? (bus.access_enable_n | bus.lower_data_strobe) // [RULE8]
                             : bus.access_enable_n;

    // two-stage synchronisers, first stage read only by the second
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sel_sync_q <= 2'h0;
            rd_sync_q  <= 2'h0;
            wr_sync_q  <= 2'h0;
        end
        else
        begin
            sel_sync_q <= {sel_sync_q[0], !sel_n}; // [RULE18]
            rd_sync_q  <= {rd_sync_q[0],
                           pin_read(ack_style, bus.direction_select, bus.read_strobe_n)};
            wr_sync_q  <= {wr_sync_q[0],
                           pin_write(ack_style, bus.direction_select, bus.store_strobe_n)};
        end
    end

    // request decode; strobes ignored without select
    assign rd_req = !bus.multiplexed_bus_select && sel_sync_q[1] && rd_sync_q[1]; // [RULE4] [RULE5] [RULE7]
    assign wr_req = !bus.multiplexed_bus_select && sel_sync_q[1] && wr_sync_q[1]
                    && !(ack_style && rd_sync_q[1]); // [RULE6] [RULE7]

    // access sequencer: one access per host cycle
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q   <= IDLE;
            is_read_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                IDLE:
                begin
                    if (rd_req)
                    begin
                        state_q   <= RD_WAIT;
                        is_read_q <= 1'b1;
                    end
                    else if (wr_req)
                    begin
                        state_q   <= ANSWER; // [RULE13]
                        is_read_q <= 1'b0;
                    end
                end
                RD_WAIT:
                    if (mem_rvalid)
                        state_q <= ANSWER;
                    else if (!sel_sync_q[1])
                        state_q <= IDLE;
                ANSWER:
                    if (!sel_sync_q[1] || !(rd_req || wr_req))
                        state_q <= RELEASE; // [RULE18]
                RELEASE:
                    state_q <= IDLE;
                default:
                    state_q <= IDLE;
            endcase
        end
    end

    // internal memory strobes, one cycle each
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_rd    <= 1'b0;
            mem_wr    <= 1'b0;
            mem_addr  <= 11'h000;
            mem_wdata <= 8'h00;
        end
        else
        begin
            mem_rd <= (state_q == IDLE) && rd_req;
            mem_wr <= (state_q == IDLE) && !rd_req && wr_req; // [RULE6]
            if (state_q == IDLE)
            begin
                mem_addr  <= bus.addr; // [RULE2]
                mem_wdata <= bus.data_bus; // [RULE3]
            end
        end
    end

    // captured read data
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            rdata_q <= 8'h00;
        else if (state_q == RD_WAIT && mem_rvalid)
            rdata_q <= mem_rdata;
    end

    // answer of a host cycle that has ended; keeps it off the next cycle's pins
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            stale_q <= 1'b0;
        else if (state_q == IDLE || state_q == RELEASE)
            stale_q <= 1'b0;
        else if (sel_n)
            stale_q <= 1'b1; // [RULE18]
    end

    // live answer: current select only, never a leftover one
    assign answer_live = (state_q == ANSWER) && !sel_n && !stale_q;

    // data bus driven only while a read is answered
    assign bus.data_from_dev    = rdata_q;
    assign bus.data_from_dev_oe = answer_live && is_read_q // [RULE3]
        && pin_read(ack_style, bus.direction_select, bus.read_strobe_n);

    // ready: high unselected or once the access is done, low while busy
    always_comb
    begin
        if (sel_n)
            bus.transfer_ready = 1'b1; // [RULE10]
        else
            bus.transfer_ready = answer_live; // [RULE10] [RULE11]
    end
    assign bus.transfer_ready_oe = !ack_style && !bus.multiplexed_bus_select
                                   && !bus.access_enable_n;

    // acknowledge: low only once data valid or accepted, else released
    assign bus.transfer_acknowledge_n  = 1'b0; // [RULE12] [RULE13]
    assign bus.transfer_acknowledge_oe = ack_style && answer_live; // [RULE14]

    // interrupt output at the strapped polarity
    always_comb
    begin
        if (bus.request_polarity_pin)
            bus.service_request_out = irq_pending; // [RULE15]
        else
            bus.service_request_out = !irq_pending; // [RULE16]
    end
endmodule
`default_nettype wire

// >>> logic/split_host_bus_host.sv
/*
 * host end of the split host bus port: runs one read or write per command
 * in the style selected by the strobe style pin.
 * assumes the device end answers with ready or acknowledge.
 */
`timescale 1ns/1ps
`default_nettype none
module split_host_bus_host (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // device pins
    split_host_bus_if.host   bus,
    // command port
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_write,
    input  wire logic [10:0] cmd_addr,
    input  wire logic [7:0]  cmd_wdata,
    output logic             rsp_valid,
    output logic [7:0]       rsp_rdata,
    output logic             rsp_timeout,
    output logic             irq
);
    typedef enum logic [1:0] {H_IDLE, H_STROBE, H_WAIT, H_END} hstate_e;

    hstate_e    state_q;
    logic       write_q;
    logic [10:0] addr_q;
    logic [7:0] wdata_q;
    logic [3:0] width_q;
    logic [6:0] tmo_q;
    logic       done;
    logic       ack_style;

    assign ack_style = bus.strobe_style_select;
    assign cmd_ready = (state_q == H_IDLE);
    // completion seen from whichever answer the style uses
    assign done = ack_style ? (bus.transfer_acknowledge_oe && !bus.transfer_acknowledge_n)
                            : (bus.transfer_ready_oe && bus.transfer_ready);

    // host cycle sequencer with wait states and timeout
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= H_IDLE;
            write_q <= 1'b0;
            addr_q  <= 11'h000;
            wdata_q <= 8'h00;
            width_q <= 4'h0;
            tmo_q   <= 7'h00;
        end
        else
        begin
            unique case (state_q)
                H_IDLE:
                    if (cmd_valid)
                    begin
                        state_q <= H_STROBE;
                        write_q <= cmd_write;
                        addr_q  <= cmd_addr; // [RULE2]
                        wdata_q <= cmd_wdata;
                        width_q <= 4'h0;
                        tmo_q   <= 7'h00;
                    end
                H_STROBE:
                begin
                    width_q <= width_q + 4'h1;
                    if (width_q == split_host_bus_pkg::HOST_STROBE_CNT)
                        state_q <= H_WAIT;
                end
                H_WAIT:
                begin
                    tmo_q <= tmo_q + 7'h01;
                    if (done || tmo_q == split_host_bus_pkg::HOST_TIMEOUT_CNT)
                        state_q <= H_END; // [RULE11]
                end
                H_END:
                    state_q <= H_IDLE;
                default:
                    state_q <= H_IDLE;
            endcase
        end
    end

    // response capture
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rsp_valid   <= 1'b0;
            rsp_rdata   <= 8'h00;
            rsp_timeout <= 1'b0;
        end
        else
        begin
            rsp_valid <= (state_q == H_WAIT) && (done
                         || tmo_q == split_host_bus_pkg::HOST_TIMEOUT_CNT);
            if (state_q == H_WAIT)
            begin
                rsp_timeout <= !done;
                if (done && !write_q)
                    rsp_rdata <= bus.data_bus; // [RULE3]
            end
        end
    end

    // pin drive: select and strobes held across strobe and wait phases
    logic active;
    assign active = (state_q == H_STROBE) || (state_q == H_WAIT);
    assign bus.addr              = addr_q;
    assign bus.access_enable_n   = !active; // [RULE4]
    assign bus.lower_data_strobe = 1'b0; // [RULE9]
    assign bus.read_strobe_n     = !(active && !ack_style && !write_q); // [RULE5]
    assign bus.store_strobe_n    = !(active && !ack_style && write_q); // [RULE6]
    assign bus.direction_select  = !write_q; // [RULE7]
    assign bus.data_from_host    = wdata_q;
    assign bus.data_from_host_oe = active && write_q; // [RULE3]
    // strap expected to match: active-high host reads polarity directly
    assign irq = bus.service_request_out; // [RULE17]
endmodule
`default_nettype wire

// >>> dv/split_host_bus_props.sv
/* pin checker for the split host bus.
   assumes one clock and an active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module split_host_bus_props (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rstn,
    // bus pins
    input wire logic [10:0] addr,
    input wire logic        data_from_dev_oe,
    input wire logic        access_enable_n,
    input wire logic        lower_data_strobe,
    input wire logic        read_strobe_n,
    input wire logic        direction_select,
    input wire logic        transfer_ready,
    input wire logic        transfer_ready_oe,
    input wire logic        transfer_acknowledge_oe,
    input wire logic        strobe_style_select,
    input wire logic        multiplexed_bus_select
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // internal select: enable or lower strobe
    wire sel_n = access_enable_n | lower_data_strobe;
    // data driven only in a selected read
    AST_DATA_READ: assert property (data_from_dev_oe |-> !sel_n &&
        (strobe_style_select ? direction_select : !read_strobe_n)) else $error("data drive");
    AST_ACK_RELEASE: assert property (sel_n |-> !transfer_acknowledge_oe)
        else $error("ack while unselected");
    AST_ACK_DATA: assert property (transfer_acknowledge_oe && direction_select
        |-> data_from_dev_oe) else $error("read ack without data");
    AST_ACK_SYNC: assert property ($fell(sel_n) |-> !transfer_acknowledge_oe [*2])
        else $error("ack before sync");
    AST_ACK_BOUND: assert property (!sel_n && strobe_style_select &&
        !multiplexed_bus_select |-> ##[0:40] transfer_acknowledge_oe) else $error("no ack");
    AST_READY_BOUND: assert property (!access_enable_n && !strobe_style_select &&
        !multiplexed_bus_select |-> ##[0:40] transfer_ready) else $error("no ready");
    AST_READY_IDLE: assert property ((access_enable_n && !strobe_style_select)[*3]
        |-> transfer_ready) else $error("ready low when idle");
    AST_READY_WAIT: assert property ($fell(access_enable_n) && !strobe_style_select &&
        !multiplexed_bus_select |-> !transfer_ready [*2]) else $error("ready before sync");
    AST_ACK_STYLE: assert property (transfer_acknowledge_oe |-> strobe_style_select &&
        !multiplexed_bus_select) else $error("ack outside its style");
    AST_ADDR_HELD: assert property (!access_enable_n && !$past(access_enable_n)
        |-> $stable(addr)) else $error("address moved");
    AST_MUX_IGNORE: assert property (multiplexed_bus_select |-> !data_from_dev_oe &&
        !transfer_acknowledge_oe) else $error("answer in mux mode");
endmodule
`default_nettype wire

// >>> dv/tb_split_host_bus_port.sv
/* bench joining host end and device end.
   assumes package and interface compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_split_host_bus_port;
    logic        ref_clk, rstn, cmd_valid, cmd_ready, cmd_write, rsp_valid;
    logic        rsp_timeout, irq, mem_rd, mem_wr, mem_rvalid, irq_pending;
    logic [10:0] cmd_addr, mem_addr, rd_a;
    logic [10:0] a [6];
    logic [7:0]  cmd_wdata, rsp_rdata, mem_wdata, mem_rdata;
    logic [7:0]  mem [2048];
    logic [7:0]  shadow [2048];
    logic [1:0]  rd_cnt;
    logic [9:0]  exp_rsp [$];
    logic [18:0] exp_wr [$];
    int          n_fail, checks, seed, cyc;
    split_host_bus_if bus_if ();
    split_host_bus_dev split_host_bus_dev_inst (.ref_clk(ref_clk), .rstn(rstn),
        .bus(bus_if), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
        .irq_pending(irq_pending));
    split_host_bus_host split_host_bus_host_inst (.ref_clk(ref_clk), .rstn(rstn),
        .bus(bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_timeout(rsp_timeout), .irq(irq));
    split_host_bus_props split_host_bus_props_inst (.ref_clk(ref_clk), .rstn(rstn),
        .addr(bus_if.addr), .data_from_dev_oe(bus_if.data_from_dev_oe),
        .access_enable_n(bus_if.access_enable_n), .read_strobe_n(bus_if.read_strobe_n),
        .lower_data_strobe(bus_if.lower_data_strobe),
        .direction_select(bus_if.direction_select), .transfer_ready(bus_if.transfer_ready),
        .transfer_ready_oe(bus_if.transfer_ready_oe),
        .transfer_acknowledge_oe(bus_if.transfer_acknowledge_oe),
        .strobe_style_select(bus_if.strobe_style_select),
        .multiplexed_bus_select(bus_if.multiplexed_bus_select));
    // free-running clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic report_and_stop();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [18:0] e, g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // read data only counts for reads
    task automatic cmp_rsp(input logic [9:0] e, input logic [8:0] g);
        cmp("response", 19'(e[8:0]), 19'(e[9] ? g : {g[8], e[7:0]}));
    endtask
    task automatic cmp_wr(input logic [18:0] e, g);
        cmp("memory write", e, g);
    endtask
    task automatic cmp_irq(input logic e, g);
        cmp("irq", 19'(e), 19'(g));
    endtask
    // one command, then wait for its answer
    task automatic do_cmd(input logic w, input logic [10:0] ad, input logic [7:0] d,
        input logic to);
        int n;
        exp_rsp.push_back({!w && !to, to, (w || to) ? 8'h00 : shadow[ad]});
        if (w && !to)
        begin
            exp_wr.push_back({ad, d});
            shadow[ad] = d;
        end
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr  <= ad;
        cmd_wdata <= d;
        do @(posedge ref_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        n = 0;
        do @(posedge ref_clk); while (rsp_valid !== 1'b1 && n++ < 200);
    endtask
    // memory behind the device, fixed read latency
    always @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            rd_cnt     <= 2'h0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= 8'h00;
        end
        else
        begin
            if (mem_wr === 1'b1)
                mem[mem_addr] <= mem_wdata;
            mem_rvalid <= (mem_rd !== 1'b1) && (rd_cnt == 2'h1);
            if (mem_rd === 1'b1)
            begin
                rd_cnt <= split_host_bus_pkg::MEM_LAT_CNT;
                rd_a   <= mem_addr;
            end
            else if (rd_cnt != 2'h0)
            begin
                rd_cnt    <= rd_cnt - 2'h1;
                mem_rdata <= mem[rd_a];
            end
        end
    end
    // output watcher and hang limit
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_fail++;
            report_and_stop();
        end
        if (rsp_valid === 1'b1)
            cmp_rsp(exp_rsp.pop_front(), {rsp_timeout, rsp_rdata});
        if (mem_wr === 1'b1)
            cmp_wr(exp_wr.pop_front(), {mem_addr, mem_wdata});
    end
    // main sequence
    initial
    begin
        seed = 89;
        n_fail = 0;
        checks = 0;
        cyc = 0;
        rstn = 1'b0;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 11'h000;
        cmd_wdata = 8'h00;
        irq_pending = 1'b0;
        bus_if.request_polarity_pin = 1'b0;
        bus_if.strobe_style_select = 1'b0;
        bus_if.multiplexed_bus_select = 1'b0;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        for (int s = 0; s < 2; s++)
        begin
            bus_if.strobe_style_select <= s[0];
            @(posedge ref_clk);
            for (int i = 0; i < 6; i++)
            begin
                a[i] = (i < 2) ? {11{i[0]}} : 11'($random(seed));
                do_cmd(1'b1, a[i], 8'($random(seed)), 1'b0);
            end
            for (int i = 0; i < 6; i++)
                do_cmd(1'b0, a[i], 8'h00, 1'b0);
            bus_if.multiplexed_bus_select <= 1'b1;
            do_cmd(s[0], 11'h055, 8'hA5, 1'b1);
            bus_if.multiplexed_bus_select <= 1'b0;
        end
        for (int k = 0; k < 4; k++)
        begin
            bus_if.request_polarity_pin <= k[1];
            irq_pending <= k[0];
            repeat (4) @(posedge ref_clk);
            cmp_irq(k[0] ~^ k[1], irq);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
